// [src/rcs_defs.svh]
// register offsets, field positions, reset values and timing counts for the
// retimer channel status slice; assumes a single 10 MHz system clock
`ifndef RCS_DEFS_SVH
`define RCS_DEFS_SVH

// ----------------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------------
`define RCS_OFS_EVENT 8'h01
`define RCS_OFS_STATUS 8'h02
`define RCS_OFS_BOOST 8'h03
`define RCS_OFS_OVR 8'h2D

// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
`define RCS_EVT_LOCK_LOSS 4
`define RCS_EVT_SIG_LOSS 0
`define RCS_ST_PPM_OK 7
`define RCS_ST_ADAPT_DONE 6
`define RCS_ST_LOCK_FAIL 5
`define RCS_ST_LOCK 4
`define RCS_ST_LOCK_MIRROR 3
`define RCS_ST_TRANS_OK 2
`define RCS_ST_LPF_HIGH 1
`define RCS_ST_LPF_LOW 0
`define RCS_OVR_ENABLE 3

// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define RCS_RST_STATUS 8'h00
`define RCS_RST_BOOST 8'h00
`define RCS_RST_EVENT 8'h00
`define RCS_RST_OVR 8'h00

// ----------------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------------
`define RCS_CLK_PERIOD_NS 100
`define RCS_READ_LATENCY 1

`endif

// [src/rcs_pkg.sv]
// types for the retimer channel status slice
// assumes rcs_defs.svh supplies the numeric constants
package rcs_pkg;

  // --------------------------------------------------------------------------
  // channel condition inputs from the analog and recovery logic
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic sig_detect;
    logic ppm_ok;
    logic adapt_done;
    logic lock_fail;
    logic locked;
    logic trans_ok;
    logic lpf_high;
    logic lpf_low;
  } rcs_cond_s;

  // --------------------------------------------------------------------------
  // register access request
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } rcs_req_s;

  // --------------------------------------------------------------------------
  // boost settings toward the equalizer
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic [1:0] stage_zero;
    logic [1:0] stage_one;
    logic [1:0] stage_two;
    logic [1:0] stage_three;
  } rcs_boost_s;

  typedef enum logic [1:0] {
    RCS_SIG_IDLE = 2'b01,
    RCS_SIG_SEEN = 2'b10
  } rcs_sig_e;

endpackage

// [src/rcs_regs.sv]
// register slice of one retimer channel: event flags, status byte, boost
// override; assumes the management bus bridge presents one-cycle read and
// write strobes synchronous to clk_sys, and condition inputs already
// synchronised to clk_sys
`include "rcs_defs.svh"

module rcs_regs #(
  parameter int REG_W = 8,
  parameter int BOOST_STAGES = 4
) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire rcs_pkg::rcs_req_s req,
  input wire rcs_pkg::rcs_cond_s cond,
  input wire rcs_pkg::rcs_boost_s adapted_boost,
  output logic [7:0] rdata,
  output logic rvalid,
  output rcs_pkg::rcs_boost_s eq_boost,
  output logic signal_loss_flag,
  output logic lock_loss_flag
);
  import rcs_pkg::*;

  // --------------------------------------------------------------------------
  // elaboration checks
  // --------------------------------------------------------------------------
  // the register map and the boost layout are fixed at byte width, four
  // two-bit stages; other values would misplace fields
  if (REG_W != 8) begin : g_bad_width
    $error("rcs_regs: REG_W must be 8");
  end
  if (BOOST_STAGES != 4) begin : g_bad_stages
    $error("rcs_regs: BOOST_STAGES must be 4");
  end

  // --------------------------------------------------------------------------
  // state
  // --------------------------------------------------------------------------
  logic [7:0] boost_adapted_flat;
  logic [7:0] boost_sel_flat;
  rcs_sig_e sig_state;
  rcs_sig_e next_sig_state;
  logic lock_seen;
  logic next_lock_seen;
  logic next_signal_loss_flag;
  logic next_lock_loss_flag;
  logic [7:0] status;
  logic [7:0] next_status;
  logic [7:0] boost_override_fields;
  logic [7:0] next_boost_override_fields;
  logic [7:0] override_ctrl;
  logic [7:0] next_override_ctrl;
  logic [7:0] next_rdata;
  logic next_rvalid;
  rcs_boost_s next_eq_boost;
  logic event_rd;

  assign event_rd = req.rd && (req.addr == `RCS_OFS_EVENT);
  assign boost_adapted_flat = adapted_boost;

  // --------------------------------------------------------------------------
  // per-stage boost selection
  // --------------------------------------------------------------------------
  // one enable covers all stages so a partial override is never seen
  for (genvar g = 0; g < BOOST_STAGES; g++) begin : g_stage
    assign boost_sel_flat[2*g+1:2*g] = override_ctrl[`RCS_OVR_ENABLE] ?
      boost_override_fields[2*g+1:2*g] : boost_adapted_flat[2*g+1:2*g];
  end

  // --------------------------------------------------------------------------
  // event flags
  // --------------------------------------------------------------------------
  always_comb begin
    next_sig_state = sig_state;
    next_signal_loss_flag = signal_loss_flag;
    next_lock_seen = lock_seen;
    next_lock_loss_flag = lock_loss_flag;
    // both flags clear on a read of the event register; a new event in the
    // same cycle still wins so nothing is lost
    if (event_rd) begin
      next_signal_loss_flag = 1'b0;
      next_lock_loss_flag = 1'b0;
    end
    case (sig_state)
      RCS_SIG_IDLE: begin
        if (cond.sig_detect) begin
          next_sig_state = RCS_SIG_SEEN;
        end
      end
      RCS_SIG_SEEN: begin
        if (!cond.sig_detect) begin
          next_sig_state = RCS_SIG_IDLE;
          next_signal_loss_flag = 1'b1;
        end
      end
      default: begin
        next_sig_state = RCS_SIG_IDLE;
      end
    endcase
    if (cond.locked) begin
      next_lock_seen = 1'b1;
    end else if (lock_seen) begin
      next_lock_seen = 1'b0;
      next_lock_loss_flag = 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      sig_state <= RCS_SIG_IDLE;
      signal_loss_flag <= 1'b0;
      lock_seen <= 1'b0;
      lock_loss_flag <= 1'b0;
    end else begin
      sig_state <= next_sig_state;
      signal_loss_flag <= next_signal_loss_flag;
      lock_seen <= next_lock_seen;
      lock_loss_flag <= next_lock_loss_flag;
    end
  end

  // --------------------------------------------------------------------------
  // status byte, sampled every cycle, never written
  // --------------------------------------------------------------------------
  always_comb begin
    next_status = `RCS_RST_STATUS;
    next_status[`RCS_ST_PPM_OK] = cond.ppm_ok;
    next_status[`RCS_ST_ADAPT_DONE] = cond.adapt_done;
    next_status[`RCS_ST_LOCK_FAIL] = cond.lock_fail;
    next_status[`RCS_ST_LOCK] = cond.locked;
    next_status[`RCS_ST_LOCK_MIRROR] = cond.locked;
    next_status[`RCS_ST_TRANS_OK] = cond.trans_ok;
    next_status[`RCS_ST_LPF_HIGH] = cond.lpf_high;
    next_status[`RCS_ST_LPF_LOW] = cond.lpf_low;
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      status <= `RCS_RST_STATUS;
    end else begin
      status <= next_status;
    end
  end

  // --------------------------------------------------------------------------
  // writable registers and boost selection
  // --------------------------------------------------------------------------
  always_comb begin
    next_boost_override_fields = boost_override_fields;
    next_override_ctrl = override_ctrl;
    // writes to the status offset fall through untouched
    if (req.wr && (req.addr == `RCS_OFS_BOOST)) begin
      next_boost_override_fields = req.wdata;
    end else if (req.wr && (req.addr == `RCS_OFS_OVR)) begin
      next_override_ctrl = req.wdata;
    end
    next_eq_boost = rcs_boost_s'(boost_sel_flat);
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      boost_override_fields <= `RCS_RST_BOOST;
      override_ctrl <= `RCS_RST_OVR;
      eq_boost <= rcs_boost_s'(8'h00);
    end else begin
      boost_override_fields <= next_boost_override_fields;
      override_ctrl <= next_override_ctrl;
      eq_boost <= next_eq_boost;
    end
  end

  // --------------------------------------------------------------------------
  // read path
  // --------------------------------------------------------------------------
  always_comb begin
    next_rvalid = req.rd;
    next_rdata = 8'h00;
    if (!req.rd) begin
      next_rdata = 8'h00;
    end else if (req.addr == `RCS_OFS_EVENT) begin
      next_rdata[`RCS_EVT_LOCK_LOSS] = lock_loss_flag;
      next_rdata[`RCS_EVT_SIG_LOSS] = signal_loss_flag;
    end else if (req.addr == `RCS_OFS_STATUS) begin
      next_rdata = status;
    end else if (req.addr == `RCS_OFS_BOOST) begin
      next_rdata = boost_override_fields;
    end else if (req.addr == `RCS_OFS_OVR) begin
      next_rdata = override_ctrl;
    end else begin
      next_rdata = 8'h00;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      rdata <= 8'h00;
      rvalid <= 1'b0;
    end else begin
      rdata <= next_rdata;
      rvalid <= next_rvalid;
    end
  end

endmodule

// [dv/rcs_regs_asserts.sv]
// checker for the channel status slice
// bound to rcs_regs; sees its ports only
module rcs_regs_chk (
  input wire logic clk_sys,
  input wire logic srst,
  input wire rcs_pkg::rcs_req_s req,
  input wire rcs_pkg::rcs_cond_s cond,
  input wire logic [7:0] rdata,
  input wire logic rvalid,
  input wire rcs_pkg::rcs_boost_s eq_boost,
  input wire logic signal_loss_flag,
  input wire logic lock_loss_flag
);
  import rcs_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] st_exp;
  // ----
  // assertions
  // ----
  always_comb st_exp = {cond[6:3], cond[3], cond[2:0]};
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);
  sequence s_ovr_on;
    req.wr && req.addr == 8'h2D && req.wdata[3];
  endsequence
  sequence s_bst_wr;
    req.wr && req.addr == 8'h03;
  endsequence
  a_read_answer: assert property (req.rd |=> rvalid)
    else $error("read not answered");
  a_idle_zero: assert property (!rvalid |-> rdata == 8'h00)
    else $error("rdata not zero when idle");
  // the two-deep window skips reads that straddle reset release
  a_status_live: assert property (rvalid && $past(req.addr) == 8'h02 && !$past(srst, 2)
    && !$past(srst, 3) |-> rdata == $past(st_exp, 2)) else $error("status mismatch");
  a_mirror_bits: assert property (rvalid && $past(req.addr) == 8'h02 |-> rdata[4] == rdata[3])
    else $error("lock bits differ");
  a_sig_rise: assert property ($rose(signal_loss_flag) |-> !$past(cond.sig_detect))
    else $error("signal loss without loss");
  a_lock_rise: assert property ($rose(lock_loss_flag) |-> !$past(cond.locked))
    else $error("lock loss while locked");
  a_event_clear: assert property (req.rd && req.addr == 8'h01 && cond.locked && $past(cond.locked)
    |=> !lock_loss_flag) else $error("event not cleared");
  a_boost_apply: assert property (s_ovr_on ##1 s_bst_wr |=> ##1 eq_boost == $past(req.wdata, 2))
    else $error("forced boost not applied");
endmodule
bind rcs_regs rcs_regs_chk u_chk (.clk_sys(clk_sys), .srst(srst), .req(req), .cond(cond), .rdata(rdata),
  .rvalid(rvalid), .eq_boost(eq_boost), .signal_loss_flag(signal_loss_flag), .lock_loss_flag(lock_loss_flag));

// [dv/tb_top.sv]
// self-checking bench for the channel status slice
// assumes one-cycle read latency on a 10 MHz clock
`define CK(n, e, g) begin n_tests++; if ((g) !== (e)) begin fail_count++; \
  $display("BAD %s exp %h got %h", n, e, g); end end
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import rcs_pkg::*;
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  rcs_req_s req = '0;
  rcs_cond_s cond = '0;
  rcs_boost_s adapted_boost = '0;
  logic [7:0] rdata;
  logic rvalid;
  rcs_boost_s eq_boost;
  logic signal_loss_flag;
  logic lock_loss_flag;
  int fail_count = 0;
  int n_tests = 0;
  logic [7:0] d;
  always #50 clk_sys = ~clk_sys;
  rcs_regs dut (.clk_sys(clk_sys), .srst(srst), .req(req), .cond(cond), .adapted_boost(adapted_boost),
    .rdata(rdata), .rvalid(rvalid), .eq_boost(eq_boost), .signal_loss_flag(signal_loss_flag),
    .lock_loss_flag(lock_loss_flag));
  // ----
  // bus and condition tasks
  // ----
  task wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk_sys);
    req <= '{1'b0, 1'b1, a, v};
  endtask
  task rd(input logic [7:0] a);
    @(posedge clk_sys);
    req <= '{1'b1, 1'b0, a, 8'h00};
    @(posedge clk_sys);
    req <= '0;
    #1;
    `CK("rvalid", 1'b1, rvalid)
    d = rdata;
  endtask
  task cyc(input int n);
    @(posedge clk_sys);
    req <= '0;
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task setc(input logic [7:0] c);
    @(posedge clk_sys);
    cond <= rcs_cond_s'(c);
  endtask
  task t_reset();
    rd(8'h02);
    `CK("status", 8'h00, d)
    rd(8'h03);
    `CK("boost", 8'h00, d)
    rd(8'h01);
    `CK("events", 8'h00, d)
    $display("t_reset done");
  endtask
  task t_status();
    logic [7:0] c;
    for (int i = 0; i < 7; i++) begin
      c = 8'h01 << i;
      setc(c);
      cyc(2);
      wr(8'h02, 8'hFF);
      rd(8'h02);
      `CK("status", {c[6:3], c[3], c[2:0]}, d)
    end
    $display("t_status done");
  endtask
  task t_events();
    `CK("no signal", 1'b0, signal_loss_flag)
    rd(8'h01);
    rd(8'h01);
    `CK("events", 8'h00, d)
    setc(8'h88);
    cyc(2);
    setc(8'h00);
    cyc(3);
    `CK("sig flag", 1'b1, signal_loss_flag)
    `CK("lock flag", 1'b1, lock_loss_flag)
    setc(8'h08);
    cyc(2);
    rd(8'h01);
    `CK("events", 8'h11, d)
    rd(8'h01);
    `CK("cleared", 8'h00, d)
    $display("t_events done");
  endtask
  task t_boost();
    @(posedge clk_sys);
    adapted_boost <= rcs_boost_s'(8'h5A);
    cyc(2);
    `CK("adapted", 8'h5A, eq_boost)
    wr(8'h2D, 8'h08);
    wr(8'h03, 8'hC3);
    cyc(2);
    `CK("forced", 8'hC3, eq_boost)
    rd(8'h03);
    `CK("boost", 8'hC3, d)
    rd(8'h2D);
    `CK("ovr ctrl", 8'h08, d)
    rd(8'h10);
    `CK("unmapped", 8'h00, d)
    wr(8'h2D, 8'h00);
    cyc(2);
    `CK("released", 8'h5A, eq_boost)
    $display("t_boost done");
  endtask
  task t_rerun();
    setc(8'h88);
    cyc(2);
    setc(8'h00);
    cyc(2);
    @(posedge clk_sys);
    srst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    srst <= 1'b0;
    #1;
    `CK("sig reset", 1'b0, signal_loss_flag)
    `CK("lock reset", 1'b0, lock_loss_flag)
    rd(8'h01);
    `CK("events reset", 8'h00, d)
    $display("t_rerun done");
  endtask
  task final_report();
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge clk_sys);
    srst <= 1'b0;
    t_reset();
    t_status();
    t_events();
    t_boost();
    t_rerun();
    final_report();
  end
endmodule
